// ---- logic/shpf_consts.svh ----
// shared constants of the spi host port with ping-pong transmit fifo
`ifndef SHPF_CONSTS_SVH
`define SHPF_CONSTS_SVH
`define SHPF_BUF_BYTES 128
`define SHPF_ERASED 8'hFF
`define SHPF_RX_HI 16
`define SHPF_RX_LO 8
`define SHPF_CLR_BITS 8
`define SHPF_CLK_NS 10
`define SHPF_T_RDY_MIN_NS 2000
`define SHPF_RDY_MIN_CYC ((`SHPF_T_RDY_MIN_NS + `SHPF_CLK_NS - 1) / `SHPF_CLK_NS)
`define SHPF_T_TXTO_NS 30000
`define SHPF_TXTO_CYC (`SHPF_T_TXTO_NS / `SHPF_CLK_NS)
`endif

// ---- logic/shpf_pkg.sv ----
// types of the spi host port
`default_nettype none
package shpf_pkg;
	typedef enum logic {shpf_rdy_lo, shpf_rdy_hi} shpf_rdy_t;
	typedef struct packed {
		logic [2:0] cs_sy, sck_sy, mosi_sy;
		logic [7:0] rx_sh;
		logic [2:0] bitc;
		logic [3:0] tot;
		logic zero8;
		logic push;
		logic [7:0] pdata;
		logic [7:0] tx_sh;
		logic tx_buf, need_load, miso;
		logic [7:0] tx_addr;
		logic [255:0][7:0] mem;
		logic [1:0] full;
		logic [1:0][7:0] len;
		logic wr_buf, rd_buf;
		logic [6:0] wr_idx;
		logic [7:0] rd_idx;
		logic last_local, read_mode, to_seen, to_arm, to_fire;
		logic [11:0] to_cnt;
		logic rx_hold, want;
		shpf_rdy_t rdy;
		logic [7:0] hold, lo_run;
		logic [4:0] flags;
		logic spi_rst, resp_rdy, done_buf;
		logic [7:0] done_addr;
	} shpf_state_t;
endpackage
`default_nettype wire

// ---- logic/shpf_port.sv ----
// spi host port: receive fifo and ping-pong transmit buffer with ready
`include "shpf_consts.svh"
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// receive fifo
// ----------------------------------------
module shpf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	localparam int AW = $clog2(DEPTH)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [AW:0] count
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp, rp;
		logic [AW:0] cnt;
	} shpf_fifo_st_t;
	shpf_fifo_st_t q, n;
	logic push, pop;
	if (DEPTH < 2 || DEPTH != 2 ** AW || WIDTH < 1) begin : g_chk
		$error("fifo depth must be a power of two");
	end
	assign in_ready = q.cnt != (AW + 1)'(DEPTH);
	assign out_valid = q.cnt != '0;
	assign out_data = q.mem[q.rp];
	assign count = q.cnt;
	always_comb begin
		n = q;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			n.mem[q.wp] = in_data;
			n.wp = q.wp + 1'b1;
		end
		if (pop)
			n.rp = q.rp + 1'b1;
		n.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		// storage keeps stale words; an empty count hides them
		if (flush || rst) begin
			n.wp = '0;
			n.rp = '0;
			n.cnt = '0;
		end
	end
	always_ff @(posedge clk) begin
		q <= n;
	end
endmodule // shpf_fifo

// ----------------------------------------
// host port top
// ----------------------------------------
module shpf_port #(
	parameter int RX_DEPTH = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cs_n_pin,
	input wire logic sclk_pin,
	input wire logic mosi_pin,
	output logic miso,
	output logic ready,
	input wire logic active_mode,
	input wire logic read_cmd,
	input wire logic resp_valid,
	input wire logic [7:0] resp_data,
	input wire logic resp_local,
	output logic resp_ready,
	output logic cmd_valid,
	input wire logic cmd_ready,
	output logic [7:0] cmd_data,
	input wire logic flag_clr,
	output logic clear_detected_flag,
	output logic clear_malformed_flag,
	output logic local_tx_cut_flag,
	output logic partial_rx_cut_flag,
	output logic chain_tx_cut_flag,
	output logic read_mode,
	output logic spi_reset
);
	localparam int RAW = $clog2(RX_DEPTH);
	localparam int RDY_CYC = `SHPF_RDY_MIN_CYC;
	localparam int TO_CYC = `SHPF_TXTO_CYC;
	localparam int RDY_W = 210;
	shpf_pkg::shpf_state_t q, n;
	logic [RAW:0] rx_cnt;
	logic rx_room;
	logic cs_fall, cs_rise, cs_low, sck_rise, sck_fall, mosi_b;
	logic done, load, fire, acc, clr_ok, clr_bad, pend;
	logic [7:0] byte_in;
	if (RX_DEPTH < 2 * `SHPF_RX_HI || RDY_CYC > 255 || TO_CYC > 4095) begin : g_chk
		$error("parameters out of range");
	end
	shpf_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx (
		.clk(ref_clk),
		.rst(rst),
		.flush(q.spi_rst),
		.in_valid(q.push),
		.in_ready(rx_room),
		.in_data(q.pdata),
		.out_valid(cmd_valid),
		.out_ready(cmd_ready),
		.out_data(cmd_data),
		.count(rx_cnt)
	);
	assign miso = q.miso;
	assign ready = (q.rdy == shpf_pkg::shpf_rdy_hi);
	assign resp_ready = q.resp_rdy;
	assign {chain_tx_cut_flag, partial_rx_cut_flag, local_tx_cut_flag} = q.flags[4:2];
	assign {clear_malformed_flag, clear_detected_flag} = q.flags[1:0];
	assign read_mode = q.read_mode;
	assign spi_reset = q.spi_rst;
	always_comb begin
		n = q;
		n.push = 1'b0;
		n.spi_rst = 1'b0;
		n.to_fire = 1'b0;
		n.done_buf = 1'b0;
		done = 1'b0;
		load = 1'b0;
		fire = 1'b0;
		// first stage feeds only the second
		n.cs_sy = {q.cs_sy[1:0], cs_n_pin};
		n.sck_sy = {q.sck_sy[1:0], sclk_pin};
		n.mosi_sy = {q.mosi_sy[1:0], mosi_pin};
		cs_low = !q.cs_sy[1];
		cs_fall = !q.cs_sy[1] && q.cs_sy[2];
		cs_rise = q.cs_sy[1] && !q.cs_sy[2];
		sck_rise = q.sck_sy[1] && !q.sck_sy[2];
		sck_fall = !q.sck_sy[1] && q.sck_sy[2];
		mosi_b = q.mosi_sy[1];
		byte_in = {q.rx_sh[6:0], mosi_b};
		// frame edges; no idle abort, partial frames wait for the frame decoder
		if (cs_fall) begin
			n.bitc = 3'h0;
			n.tot = 4'h0;
			n.zero8 = 1'b1;
			load = 1'b1;
		end
		if (cs_low && sck_rise) begin
			n.rx_sh = byte_in;
			n.bitc = q.bitc + 3'h1;
			if (q.tot != 4'hF)
				n.tot = q.tot + 4'h1;
			if (q.tot < 4'(`SHPF_CLR_BITS) && mosi_b)
				n.zero8 = 1'b0;
			if (q.bitc == 3'h7) begin
				done = 1'b1;
				n.need_load = 1'b1;
			end
		end
		// host bytes are dropped while the device answers
		if (done && !q.read_mode && rx_room) begin
			n.push = 1'b1;
			n.pdata = byte_in;
		end
		if (done && q.tx_buf) begin
			n.mem[q.tx_addr] = `SHPF_ERASED;
			n.done_buf = 1'b1;
			n.done_addr = q.tx_addr;
			n.tx_buf = 1'b0;
			n.rd_idx = q.rd_idx + 8'h01;
			if (q.rd_idx + 8'h01 == q.len[q.rd_buf]) begin
				n.full[q.rd_buf] = 1'b0;
				n.rd_buf = !q.rd_buf;
				n.rd_idx = 8'h00;
				n.want = n.want || q.full[!q.rd_buf];
			end
		end
		if (cs_low && sck_fall) begin
			load = load || q.need_load;
			n.tx_sh = {q.tx_sh[6:0], 1'b1};
		end
		if (load) begin
			n.need_load = 1'b0;
			if (q.read_mode && q.full[q.rd_buf]) begin
				n.tx_addr = {q.rd_buf, q.rd_idx[6:0]};
				n.tx_sh = q.mem[{q.rd_buf, q.rd_idx[6:0]}];
				n.tx_buf = 1'b1;
				// drop while the last byte is still in the shifter
				if (q.rd_idx + 8'h01 == q.len[q.rd_buf]) begin
					n.want = 1'b0;
				end
			end else begin
				n.tx_sh = `SHPF_ERASED;
				n.tx_buf = 1'b0;
			end
		end
		n.miso = cs_low ? n.tx_sh[7] : 1'b1;
		// chain bytes; never overwrite unread data
		acc = resp_valid && q.read_mode && !q.to_seen;
		if (acc) begin
			n.to_arm = 1'b1;
			n.to_cnt = 12'h000;
			n.last_local = resp_local;
			if (!q.full[q.wr_buf]) begin
				n.mem[{q.wr_buf, q.wr_idx}] = resp_data;
				n.wr_idx = q.wr_idx + 7'h01;
				if (q.wr_idx == 7'h7F) begin
					n.full[q.wr_buf] = 1'b1;
					n.len[q.wr_buf] = 8'(`SHPF_BUF_BYTES);
					n.wr_buf = !q.wr_buf;
					n.want = 1'b1;
				end
			end
		end else if (q.to_arm) begin
			n.to_cnt = q.to_cnt + 12'h001;
			if (q.to_cnt == 12'(TO_CYC - 1)) begin
				fire = 1'b1;
			end
		end
		if (fire) begin
			n.to_arm = 1'b0;
			n.to_fire = 1'b1;
			n.to_seen = 1'b1;
			if (q.wr_idx != 7'h00) begin
				n.full[q.wr_buf] = 1'b1;
				n.len[q.wr_buf] = {1'b0, q.wr_idx};
				n.wr_buf = !q.wr_buf;
				n.wr_idx = 7'h00;
			end
			n.want = 1'b1;
		end
		if (q.to_seen && q.full == 2'b00 && !q.tx_buf && q.read_mode) begin
			n.read_mode = 1'b0;
			n.want = 1'b1;
		end
		if (!q.read_mode) begin
			if (rx_cnt >= (RAW + 1)'(`SHPF_RX_HI)) begin
				n.want = 1'b0;
				n.rx_hold = 1'b1;
			end else if (q.rx_hold && rx_cnt < (RAW + 1)'(`SHPF_RX_LO)) begin
				n.want = 1'b1;
				n.rx_hold = 1'b0;
			end
		end
		if (read_cmd) begin
			n.read_mode = 1'b1;
			n.to_seen = 1'b0;
			n.rx_hold = 1'b0;
			n.want = 1'b0;
		end
		// comm clear on select rising
		clr_ok = cs_rise && q.zero8 && q.tot == 4'(`SHPF_CLR_BITS);
		clr_bad = cs_rise && q.zero8 && q.tot > 4'(`SHPF_CLR_BITS);
		pend = q.full != 2'b00 || q.wr_idx != 7'h00;
		if (flag_clr)
			n.flags = 5'h00;
		if (clr_bad)
			n.flags[1] = 1'b1;
		if (clr_ok && active_mode) begin
			n.flags[0] = 1'b1;
			n.flags[2] = q.flags[2] || (pend && q.last_local);
			n.flags[3] = q.flags[3] || rx_cnt != '0;
			n.flags[4] = q.flags[4] || (pend && !q.last_local);
			n.spi_rst = 1'b1;
			n.full = 2'b00;
			n.wr_buf = 1'b0;
			n.rd_buf = 1'b0;
			n.wr_idx = 7'h00;
			n.rd_idx = 8'h00;
			n.tx_buf = 1'b0;
			n.push = 1'b0;
			n.mem = '1;
		end
		// ready never gates data above, it only reports
		case (q.rdy)
			shpf_pkg::shpf_rdy_hi: begin
				if (!n.want || fire) begin
					n.rdy = shpf_pkg::shpf_rdy_lo;
					n.hold = 8'(RDY_CYC);
				end
			end
			shpf_pkg::shpf_rdy_lo: begin
				if (q.hold != 8'h00) begin
					n.hold = q.hold - 8'h01;
				end else if (n.want) begin
					n.rdy = shpf_pkg::shpf_rdy_hi;
				end
			end
			default: n.rdy = shpf_pkg::shpf_rdy_lo;
		endcase
		n.lo_run = (q.rdy == shpf_pkg::shpf_rdy_lo) ? ((q.lo_run == 8'hFF) ? 8'hFF : q.lo_run + 8'h01) : 8'h00;
		n.resp_rdy = n.read_mode && !n.to_seen && !n.full[n.wr_buf];
		if (rst) begin
			n = '0;
			n.mem = '1;
			n.cs_sy = 3'h7;
			n.sck_sy = 3'h0;
			n.mosi_sy = 3'h7;
			n.miso = 1'b1;
			n.tx_sh = `SHPF_ERASED;
			n.want = 1'b1;
			n.rdy = shpf_pkg::shpf_rdy_hi;
		end
	end
	always_ff @(posedge ref_clk) begin
		q <= n;
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	rdy_min_low_a: assert property ($rose(ready) |-> q.lo_run >= 8'(RDY_CYC)) else $error("ready low too short");
	erase_done_a: assert property (q.done_buf |-> q.mem[q.done_addr] == 8'hFF) else $error("byte not erased");
	rx_high_low_a: assert property ((!q.read_mode && rx_cnt >= 16) |-> ##[0:RDY_W] (!ready || q.read_mode))
		else $error("ready not dropped on full rx");
	rx_low_high_a: assert property ((q.rx_hold && !q.read_mode && rx_cnt < 8) |-> ##[0:RDY_W] (ready || q.read_mode || rx_cnt >= 16))
		else $error("ready not raised on drained rx");
	rdcmd_low_a: assert property ((read_cmd && !q.spi_rst) |-> ##[1:2] !ready) else $error("ready not dropped on read");
	to_pulse_a: assert property ((q.to_fire && $past(ready)) |-> !ready ##1 !ready) else $error("no timeout pulse");
	to_timer_a: assert property (q.to_fire |-> !$past(resp_valid && q.read_mode, 1) && $past(q.to_cnt) == 12'(TO_CYC - 1))
		else $error("timeout at wrong count");
	drop_full_a: assert property ((resp_valid && q.read_mode && !q.to_seen && q.full == 2'b11 && !q.spi_rst)
		|=> q.wr_idx == $past(q.wr_idx)) else $error("byte written into full buffers");
	discard_rd_a: assert property (q.read_mode |=> !q.push) else $error("host byte kept in read mode");
	clear_empty_a: assert property (q.spi_rst |-> q.full == 2'b00 && q.wr_idx == 7'h00 ##1 rx_cnt == '0)
		else $error("clear left data");
	malformed_a: assert property ($rose(clear_malformed_flag) |-> !$rose(clear_detected_flag))
		else $error("both clear flags set");
	rd_ready_c: cover property ($rose(ready) && q.read_mode);
	clear_c: cover property (q.spi_rst);
	to_pulse_c: cover property (q.to_fire && $past(ready));
	bad_clear_c: cover property ($rose(clear_malformed_flag));
endmodule // shpf_port
`default_nettype wire

// ---- sim/shpf_host.sv ----
// spi host controller model driving the host port pins
`timescale 1ns/100ps
`default_nettype none
module shpf_host (
	input wire logic ref_clk,
	input wire logic miso,
	output var logic cs_n,
	output var logic sclk,
	output var logic mosi,
	output var logic [7:0] rx_byte,
	output var logic rx_stb
);
	initial begin
		cs_n = 1'h1;
		sclk = 1'h0; // idle low, still outside frames
		mosi = 1'h1;
		rx_byte = 8'h00;
		rx_stb = 1'h0;
	end
	// ----------------------------------------
	// bus phases
	// ----------------------------------------
	// eight cycles a phase: 160 ns serial period
	task automatic half();
		repeat (8) @(posedge ref_clk);
		#1;
	endtask
	task automatic sel(input logic v);
		half();
		cs_n = !v; // frame bounds, raised by sel(0) after a frame's last bit
		half();
	endtask
	// nbits may exceed eight, extra bits are zero; chk hands the byte to the bench
	task automatic xfer(input logic [7:0] d, input int nbits, input logic chk);
		logic [7:0] q;
		q = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			mosi = d[7]; // change on falling edge, msb first
			d = {d[6:0], 1'h0};
			half();
			sclk = 1'h1;
			q = {q[6:0], miso}; // sample on rising edge
			half();
			sclk = 1'h0;
		end
		mosi = 1'h1; // idle high between frames
		if (chk) begin // frames sent with chk low leave miso unread
			rx_byte = q;
			rx_stb = 1'h1;
			@(posedge ref_clk);
			#1;
			rx_stb = 1'h0;
		end
	endtask
endmodule // shpf_host
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench of the spi host port
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic ref_clk, rst, miso, ready, active_mode, read_cmd, resp_valid, resp_local, resp_ready, cmd_valid;
	logic cmd_ready, cmd_en, flag_clr, f_det, f_bad, f_loc, f_part, f_chain, read_mode, spi_reset, cs_n, sclk, mosi, rx_stb;
	logic [7:0] resp_data, cmd_data, rx_byte;
	logic [7:0] exp_cmd[$];
	logic [7:0] exp_miso[$];
	logic [31:0] seed = 32'h3;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_rst = 0;
	int n;
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = !ref_clk;
	end
	shpf_port dut_u (.ref_clk(ref_clk), .rst(rst), .cs_n_pin(cs_n), .sclk_pin(sclk), .mosi_pin(mosi), .miso(miso),
		.ready(ready), .active_mode(active_mode), .read_cmd(read_cmd), .resp_valid(resp_valid),
		.resp_data(resp_data), .resp_local(resp_local), .resp_ready(resp_ready), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_data(cmd_data), .flag_clr(flag_clr), .clear_detected_flag(f_det),
		.clear_malformed_flag(f_bad), .local_tx_cut_flag(f_loc), .partial_rx_cut_flag(f_part),
		.chain_tx_cut_flag(f_chain), .read_mode(read_mode), .spi_reset(spi_reset));
	shpf_host host_u (.ref_clk(ref_clk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .rx_byte(rx_byte),
		.rx_stb(rx_stb));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	// bounded wait, n keeps the cycles spent
	task automatic wait_rdy(input logic v, input int lim);
		for (n = 0; n < lim && ready !== v; n++)
			tick(1);
		check("ready", v, ready);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------
	// monitor: oldest note against each result
	// ----------------------------------------
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (spi_reset === 1'h1)
			n_rst <= n_rst + 1;
		if (cmd_valid === 1'h1 && cmd_ready === 1'h1)
			check("cmd_data", exp_cmd.size() ? exp_cmd.pop_front() : 8'hXX, cmd_data);
		if (rx_stb === 1'h1)
			check("miso byte", exp_miso.size() ? exp_miso.pop_front() : 8'hXX, rx_byte);
		if (cyc == 60000) begin
			err_total++;
			test_done();
		end
	end
	// consumer takes receive bytes at random while enabled
	always @(posedge ref_clk) begin
		#1;
		cmd_ready = cmd_en && rnd() < 8'hC0;
	end
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		rst = 1'h1;
		active_mode = 1'h1;
		read_cmd = 1'h0;
		resp_valid = 1'h0;
		resp_data = 8'h00;
		resp_local = 1'h0;
		cmd_en = 1'h0;
		flag_clr = 1'h0;
		tick(20);
		rst = 1'h0;
		tick(3);
		check("idle", 8'h03, {f_det, f_bad, f_loc, f_part, f_chain, resp_ready, ready, miso});
		// stalled consumer: ready follows receive fill
		host_u.sel(1);
		for (int i = 0; i < 16; i++) begin
			exp_cmd.push_back(rnd());
			host_u.xfer(exp_cmd[i], 8, 0);
		end
		host_u.sel(0);
		wait_rdy(0, 200);
		cmd_en = 1'h1;
		wait_rdy(1, 200);
		read_cmd = 1'h1;
		tick(1);
		read_cmd = 1'h0;
		wait_rdy(0, 500);
		// ping and pong back to back, one byte too many
		resp_valid = 1'h1;
		for (int i = 0; i < 257; i++) begin
			resp_data = rnd();
			resp_local = resp_data[0];
			if (i < 256)
				exp_miso.push_back(resp_data);
			if (i == 130)
				check("ready", 0, ready);
			tick(1);
		end
		resp_valid = 1'h0;
		check("ready", 1, ready);
		check("resp_ready", 0, resp_ready);
		wait_rdy(0, 3100);
		check("timeout", 1, n > 2900);
		wait_rdy(1, 250);
		check("low pulse", 1, n > 190);
		host_u.sel(1);
		repeat (128) host_u.xfer(8'hFF, 8, 1);
		check("ready", 0, ready);
		host_u.sel(0);
		wait_rdy(1, 250);
		host_u.sel(1);
		repeat (128) host_u.xfer(8'hFF, 8, 1);
		host_u.sel(0);
		for (n = 0; n < 500 && read_mode !== 1'h0; n++)
			tick(1);
		check("read_mode", 0, read_mode);
		// drained buffers answer erased bytes
		exp_cmd.push_back(8'h5A);
		exp_miso.push_back(8'hFF);
		host_u.sel(1);
		host_u.xfer(8'h5A, 8, 1);
		host_u.sel(0);
		cmd_en = 1'h0;
		tick(10);
		check("notes left", 8'h00, 8'(exp_cmd.size() + exp_miso.size()));
		// nine zero bits: malformed, then a clean clear
		wait_rdy(1, 250);
		host_u.sel(1);
		host_u.xfer(8'h00, 9, 0);
		host_u.sel(0);
		tick(4);
		check("bad det resets", 8'h80, {f_bad, f_det, n_rst[5:0]});
		host_u.sel(1);
		host_u.xfer(8'h00, 8, 0);
		host_u.sel(0);
		tick(4);
		check("det part resets", 8'hC1, {f_det, f_part, n_rst[5:0]});
		check("cmd_valid", 0, cmd_valid);
		flag_clr = 1'h1;
		tick(1);
		flag_clr = 1'h0;
		active_mode = 1'h0;
		host_u.sel(1);
		host_u.xfer(8'h00, 8, 0);
		host_u.sel(0);
		tick(4);
		check("idle clear", 8'h01, {f_det, f_bad, f_loc, f_part, f_chain, n_rst[2:0]});
		test_done();
	end
endmodule // testbench
`default_nettype wire
